/* File: include/cwf_pkg.sv */
// Package for the CAN frame wake filter and power hold block.
// Assumes a 20 MHz system clock and a 32-bit Avalon-MM register bus.
package cwf_pkg;
    // Clock rate and derived timing
    localparam int unsigned CLK_HZ          = 20000000;
    localparam int unsigned BLINK_SECONDS   = 10;
    localparam int unsigned BLINK_CYCLES    = BLINK_SECONDS * CLK_HZ;
    localparam int unsigned BLINK_HALF_MS   = 100;
    localparam int unsigned BLINK_HALF_CYC  = BLINK_HALF_MS * (CLK_HZ / 1000);
    // Register word offsets (byte addresses)
    localparam logic [5:0] REG_CTRL     = 6'h00;
    localparam logic [5:0] REG_IDENT    = 6'h04;
    localparam logic [5:0] REG_IDMASK   = 6'h08;
    localparam logic [5:0] REG_DATA_LO  = 6'h0c;
    localparam logic [5:0] REG_DATA_HI  = 6'h10;
    localparam logic [5:0] REG_DMASK_LO = 6'h14;
    localparam logic [5:0] REG_DMASK_HI = 6'h18;
    localparam logic [5:0] REG_TIMEOUT  = 6'h1c;
    localparam logic [5:0] REG_STATUS   = 6'h20;
    localparam logic [5:0] REG_IRQ_MASK = 6'h24;
    localparam logic [5:0] REG_STATE    = 6'h28;
    // Control register fields
    localparam int unsigned CTRL_MODE_LSB = 0;
    localparam int unsigned CTRL_EXT_BIT  = 2;
    localparam int unsigned CTRL_ACK_BIT  = 3;
    // Status bits
    localparam int unsigned ST_MATCH   = 0;
    localparam int unsigned ST_TIMEOUT = 1;
    localparam int unsigned ST_IGN_ON  = 2;
    localparam int unsigned ST_IGN_OFF = 3;
    localparam int unsigned ST_W       = 4;
    // Timeout reset value and read data of unmapped addresses
    localparam logic [31:0] TIMEOUT_RST = 32'h01312d00;
    localparam logic [31:0] RD_UNMAPPED = 32'h00000000;
    // Wake modes
    typedef enum logic [1:0] {
        CWF_MODE_OFF      = 2'b00,
        CWF_MODE_WAKE     = 2'b01,
        CWF_MODE_LOSSLESS = 2'b10,
        CWF_MODE_KEEP     = 2'b11
    } cwf_mode_t;
    // Power hold states
    typedef enum logic [1:0] {
        CWF_ST_SLEEP = 2'b00,
        CWF_ST_FRAME = 2'b01,
        CWF_ST_IGN   = 2'b10
    } cwf_pwr_t;
endpackage

/* File: hw/cwf_match.sv */
// Masked comparator for identifier and data field filters.
// Assumes value, mask and received word share bit numbering.
module cwf_match #(
    parameter int unsigned W = 64
) (
    // Compared words
    input  wire logic [W-1:0] rx,
    input  wire logic [W-1:0] want,
    input  wire logic [W-1:0] mask,
    // Result
    output logic              hit
);
    // Only positions with mask 1 are compared; zero mask always hits
    assign hit = ((rx ^ want) & mask) == '0;
endmodule // cwf_match

/* File: hw/cwf_wake.sv */
// Frame wake filter, logger power hold and wake indicator.
// Assumes a receiver that presents one whole frame per one-cycle strobe,
// with data bit 0 being the first data bit seen on the bus.
// Summary of operation
// - Data field matches when every masked bit equals the content value.
// - Data bits with mask 0 are ignored.
// - Matching frames wake the logger and keep it running.
// - No matching frame for the timeout period stops the logger.
// - Data bit 0 is the first bus data bit; later bits ascend.
// - Wake indicator blinks quickly for about ten seconds after a frame wake.
// - Ignition feed starts the logger and wins over frame wake.
// - Ignition start ends when ignition drops; a held match then keeps the logger under frame hold.
// - Identifier passes when masked identifier bits equal configured value.
// - Zero mask makes a filter match every frame.
// - Timeout permits shutdown, logs an entry and raises acknowledged alert.
// - Four wake modes: disabled, enabled, lossless, keep awake; keep awake acts as enabled.
//
// Local design decisions: the Avalon-MM register port and the address map.
module cwf_wake (
    // Clock and reset
    input  wire logic        CLK,
    input  wire logic        RST_N,
    // Avalon-MM slave
    input  wire logic [5:0]  AVS_ADDRESS,
    input  wire logic        AVS_READ,
    input  wire logic        AVS_WRITE,
    input  wire logic [31:0] AVS_WRITEDATA,
    input  wire logic [3:0]  AVS_BYTEENABLE,
    output logic [31:0]      AVS_READDATA,
    output logic             AVS_WAITREQUEST,
    // Received frame from the CAN receiver
    input  wire logic        RX_VALID,
    input  wire logic        RX_EXT,
    input  wire logic [28:0] RX_IDENT,
    input  wire logic [63:0] RX_DATA,
    // Ignition feed pin
    input  wire logic        IGN_FEED,
    // Power control and indicators
    output logic             LOGGER_RUN,
    output logic             LOGGER_LOSSLESS,
    output logic             WAKE_LED,
    output logic             ALERT,
    output logic             LOG_EVENT,
    output logic             IRQ
);
    // All state of the block
    typedef struct packed {
        logic [31:0]      rdata;
        logic             ack;
        logic [1:0]       mode;
        logic             ext;
        logic [28:0]      ident;
        logic [28:0]      id_mask;
        logic [63:0]      data_val;
        logic [63:0]      data_mask;
        logic [31:0]      timeout;
        logic [31:0]      idle_cnt;
        logic [3:0]       status;
        logic [3:0]       irq_mask;
        logic [1:0]       pwr;
        logic             frame_hold;
        logic             alert;
        logic             log_ev;
        logic [31:0]      blink_cnt;
        logic [31:0]      half_cnt;
        logic             led;
        logic [1:0]       ign_sync;
        logic             ign_prev;
    } cwf_state_t;

    cwf_state_t s_q;
    cwf_state_t s_d;

    logic        id_hit;
    logic        data_hit;
    logic [28:0] id_rx;
    logic [28:0] id_mask_eff;
    logic        wake_hit;
    logic        ign;

    // Standard frames compare only the low eleven identifier bits
    assign id_rx       = s_q.ext ? RX_IDENT : {18'h0, RX_IDENT[10:0]};
    assign id_mask_eff = s_q.ext ? s_q.id_mask : {18'h0, s_q.id_mask[10:0]};

    // Identifier filter
    cwf_match #(.W(29)) u_id_match (
        .rx   (id_rx),
        .want (s_q.ident),
        .mask (id_mask_eff),
        .hit  (id_hit)
    );

    // Data field filter, bit 0 first on the bus
    cwf_match #(.W(64)) u_data_match (
        .rx   (RX_DATA),
        .want (s_q.data_val),
        .mask (s_q.data_mask),
        .hit  (data_hit)
    );

    // Frame counts only with both filters and frame wake enabled
    assign wake_hit = RX_VALID && id_hit && data_hit
                      && (s_q.ext == RX_EXT)
                      && (cwf_pkg::cwf_mode_t'(s_q.mode) != cwf_pkg::CWF_MODE_OFF);
    assign ign      = s_q.ign_sync[1];

    // Next state
    always_comb begin
        s_d        = s_q;
        s_d.log_ev = 1'b0;
        s_d.ack    = 1'b0;
        // Ignition feed synchroniser
        s_d.ign_sync = {s_q.ign_sync[0], IGN_FEED};
        s_d.ign_prev = ign;

        // Bus access: one wait cycle, then answer
        if ((AVS_READ || AVS_WRITE) && !s_q.ack) begin
            s_d.ack   = 1'b1;
            s_d.rdata = cwf_pkg::RD_UNMAPPED;
            if (AVS_WRITE) begin
                case (AVS_ADDRESS)
                    cwf_pkg::REG_CTRL: begin
                        if (AVS_BYTEENABLE[0]) begin
                            s_d.mode = AVS_WRITEDATA[cwf_pkg::CTRL_MODE_LSB +: 2];
                            s_d.ext  = AVS_WRITEDATA[cwf_pkg::CTRL_EXT_BIT];
                            if (AVS_WRITEDATA[cwf_pkg::CTRL_ACK_BIT]) begin
                                s_d.alert = 1'b0; // Alert acknowledge
                            end
                        end
                    end
                    cwf_pkg::REG_IDENT:    s_d.ident = AVS_WRITEDATA[28:0];
                    cwf_pkg::REG_IDMASK:   s_d.id_mask = AVS_WRITEDATA[28:0];
                    cwf_pkg::REG_DATA_LO:  s_d.data_val[31:0] = AVS_WRITEDATA;
                    cwf_pkg::REG_DATA_HI:  s_d.data_val[63:32] = AVS_WRITEDATA;
                    cwf_pkg::REG_DMASK_LO: s_d.data_mask[31:0] = AVS_WRITEDATA;
                    cwf_pkg::REG_DMASK_HI: s_d.data_mask[63:32] = AVS_WRITEDATA;
                    cwf_pkg::REG_TIMEOUT:  s_d.timeout = AVS_WRITEDATA;
                    cwf_pkg::REG_IRQ_MASK: s_d.irq_mask = AVS_WRITEDATA[3:0];
                    default: ;
                endcase
            end else begin
                case (AVS_ADDRESS)
                    cwf_pkg::REG_CTRL: begin
                        s_d.rdata = {28'h0, s_q.alert, s_q.ext, s_q.mode};
                    end
                    cwf_pkg::REG_IDENT:    s_d.rdata = {3'h0, s_q.ident};
                    cwf_pkg::REG_IDMASK:   s_d.rdata = {3'h0, s_q.id_mask};
                    cwf_pkg::REG_DATA_LO:  s_d.rdata = s_q.data_val[31:0];
                    cwf_pkg::REG_DATA_HI:  s_d.rdata = s_q.data_val[63:32];
                    cwf_pkg::REG_DMASK_LO: s_d.rdata = s_q.data_mask[31:0];
                    cwf_pkg::REG_DMASK_HI: s_d.rdata = s_q.data_mask[63:32];
                    cwf_pkg::REG_TIMEOUT:  s_d.rdata = s_q.timeout;
                    cwf_pkg::REG_STATUS: begin
                        s_d.rdata  = {28'h0, s_q.status};
                        s_d.status = 4'h0; // Read clears; new events below win
                    end
                    cwf_pkg::REG_IRQ_MASK: s_d.rdata = {28'h0, s_q.irq_mask};
                    cwf_pkg::REG_STATE: begin
                        s_d.rdata = {27'h0, s_q.led, s_q.frame_hold, ign, s_q.pwr};
                    end
                    default: ;
                endcase
            end
        end

        // Frame hold: each match restarts the idle period
        if (wake_hit) begin
            s_d.frame_hold = 1'b1;
            s_d.idle_cnt   = 32'h0;
            s_d.status[cwf_pkg::ST_MATCH] = 1'b1;
        end else if (s_q.frame_hold) begin
            if (s_q.idle_cnt >= s_q.timeout) begin
                s_d.frame_hold = 1'b0; // Timeout permits shutdown
                s_d.alert      = 1'b1;
                s_d.log_ev     = 1'b1;
                s_d.status[cwf_pkg::ST_TIMEOUT] = 1'b1;
            end else begin
                s_d.idle_cnt = s_q.idle_cnt + 32'h1;
            end
        end

        // Ignition edges as events
        if (ign && !s_q.ign_prev) begin
            s_d.status[cwf_pkg::ST_IGN_ON] = 1'b1;
        end
        if (!ign && s_q.ign_prev) begin
            s_d.status[cwf_pkg::ST_IGN_OFF] = 1'b1;
        end

        // Power hold arbitration
        case (cwf_pkg::cwf_pwr_t'(s_q.pwr))
            cwf_pkg::CWF_ST_SLEEP: begin
                if (ign) begin
                    s_d.pwr = cwf_pkg::CWF_ST_IGN; // Ignition wins
                end else if (wake_hit) begin
                    s_d.pwr       = cwf_pkg::CWF_ST_FRAME;
                    s_d.blink_cnt = cwf_pkg::BLINK_CYCLES;
                    s_d.half_cnt  = 32'h0;
                end
            end
            cwf_pkg::CWF_ST_FRAME: begin
                if (ign) begin
                    s_d.pwr = cwf_pkg::CWF_ST_IGN;
                end else if (!s_d.frame_hold) begin
                    s_d.pwr = cwf_pkg::CWF_ST_SLEEP;
                end
            end
            cwf_pkg::CWF_ST_IGN: begin
                // Only dropping ignition ends it; a held match passes it to frame hold
                if (!ign) begin
                    s_d.pwr = s_d.frame_hold ? cwf_pkg::CWF_ST_FRAME
                                             : cwf_pkg::CWF_ST_SLEEP;
                end
            end
            default: s_d.pwr = cwf_pkg::CWF_ST_SLEEP;
        endcase

        // Quick blink of the wake indicator during boot
        if (s_q.blink_cnt != 32'h0) begin
            s_d.blink_cnt = s_q.blink_cnt - 32'h1;
            if (s_q.half_cnt >= cwf_pkg::BLINK_HALF_CYC - 1) begin
                s_d.half_cnt = 32'h0;
                s_d.led      = ~s_q.led;
            end else begin
                s_d.half_cnt = s_q.half_cnt + 32'h1;
            end
        end else begin
            s_d.led = 1'b0;
        end
    end

    // State register
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            s_q          <= '0;
            s_q.timeout  <= cwf_pkg::TIMEOUT_RST;
            s_q.id_mask  <= 29'h0;
            s_q.ign_prev <= 1'b0;
        end else begin
            s_q <= s_d;
        end
    end

    // Outputs
    assign AVS_READDATA    = s_q.rdata;
    assign AVS_WAITREQUEST = (AVS_READ || AVS_WRITE) && !s_q.ack;
    assign LOGGER_RUN      = (s_q.pwr != cwf_pkg::CWF_ST_SLEEP);
    assign LOGGER_LOSSLESS = (cwf_pkg::cwf_mode_t'(s_q.mode) == cwf_pkg::CWF_MODE_LOSSLESS);
    assign WAKE_LED        = s_q.led;
    assign ALERT           = s_q.alert;
    assign LOG_EVENT       = s_q.log_ev;
    assign IRQ             = |(s_q.status & s_q.irq_mask);
endmodule // cwf_wake

/* File: dv/cwf_wake_chk.sv */
// Port checker for the frame wake block.
// Assumes one clock CLK and async active-low RST_N.
module cwf_wake_chk (
    // Clock and reset
    input  wire logic        CLK,
    input  wire logic        RST_N,
    // Bus
    input  wire logic        AVS_READ,
    input  wire logic        AVS_WRITE,
    input  wire logic [31:0] AVS_READDATA,
    input  wire logic        AVS_WAITREQUEST,
    // Frame, ignition and power
    input  wire logic        RX_VALID,
    input  wire logic        IGN_FEED,
    input  wire logic        LOGGER_RUN,
    input  wire logic        ALERT,
    input  wire logic        LOG_EVENT
);
    default clocking @(posedge CLK); endclocking
    default disable iff (!RST_N);
    // Bus request and its one-wait answer
    sequence s_req; $rose(AVS_READ) || $rose(AVS_WRITE); endsequence
    sequence s_ans; AVS_WAITREQUEST ##1 !AVS_WAITREQUEST; endsequence
    AST_ONE_WAIT: assert property (s_req |-> s_ans) else $error("bus wait not one cycle");
    AST_DATA_STANDS: assert property (!AVS_READ && !AVS_WRITE |=> $stable(AVS_READDATA))
        else $error("read data moved while idle");
    AST_LOG_PULSE: assert property (LOG_EVENT |=> !LOG_EVENT)
        else $error("log event longer than one cycle");
    AST_LOG_ALERT: assert property (LOG_EVENT |-> ALERT)
        else $error("timeout without alert");
    AST_TIMEOUT_STOP: assert property (LOG_EVENT && !IGN_FEED && !$past(IGN_FEED, 3)
        |-> ##[0:2] !LOGGER_RUN) else $error("logger kept running after timeout");
    AST_IGN_START: assert property (IGN_FEED [*5] |-> LOGGER_RUN)
        else $error("ignition did not start logger");
    AST_IGN_HOLDS: assert property ($fell(LOGGER_RUN) |-> !$past(IGN_FEED, 3))
        else $error("logger stopped with ignition on");
    AST_START_CAUSE: assert property ($rose(LOGGER_RUN)
        |-> $past(RX_VALID) || $past(IGN_FEED, 3)) else $error("logger started without cause");
endmodule // cwf_wake_chk

bind cwf_wake cwf_wake_chk u_chk (.CLK(CLK), .RST_N(RST_N), .AVS_READ(AVS_READ),
    .AVS_WRITE(AVS_WRITE), .AVS_READDATA(AVS_READDATA), .AVS_WAITREQUEST(AVS_WAITREQUEST),
    .RX_VALID(RX_VALID), .IGN_FEED(IGN_FEED), .LOGGER_RUN(LOGGER_RUN), .ALERT(ALERT),
    .LOG_EVENT(LOG_EVENT));

/* File: dv/cwf_node.sv */
// CAN node model: hands received frames to the wake block.
// Assumes one frame per strobe, launched just after a clock edge.
module cwf_node (
    // Clock
    input  wire logic        CLK,
    // Frame to the block
    output logic             RX_VALID,
    output logic             RX_EXT,
    output logic [28:0]      RX_IDENT,
    output logic [63:0]      RX_DATA
);
    timeunit 1ns;
    timeprecision 1ns;
    // Node number, unique on this bus
    localparam int NODE_NO = 1;
    // Lines idle before the first frame
    initial begin
        RX_VALID = 1'b0;
        RX_EXT   = 1'b0;
        RX_IDENT = '0;
        RX_DATA  = '0;
    end
    // One-cycle frame; identifier and data lines then carry inverted values
    task automatic send(input logic e, input logic [28:0] id, input logic [63:0] d);
        @(posedge CLK);
        RX_VALID <= 1'b1;
        RX_EXT   <= e;
        RX_IDENT <= id;
        RX_DATA  <= d;
        @(posedge CLK);
        RX_VALID <= 1'b0;
        RX_IDENT <= ~id;
        RX_DATA  <= ~d;
    endtask
endmodule // cwf_node

/* File: dv/tb.sv */
// Self-checking bench for the frame wake block.
// Assumes the bind in the checker file and the node model.
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic        CLK, RST_N, AVS_READ, AVS_WRITE, AVS_WAITREQUEST, IGN_FEED;
    logic        RX_VALID, RX_EXT, LOGGER_RUN, LOGGER_LOSSLESS, ALERT, LOG_EVENT, IRQ;
    logic        WAKE_LED;
    logic [5:0]  AVS_ADDRESS;
    logic [31:0] AVS_WRITEDATA, AVS_READDATA, rd_q;
    logic [28:0] RX_IDENT;
    logic [63:0] RX_DATA;
    int          miscompares, samples_checked, n;
    cwf_wake dut (.CLK(CLK), .RST_N(RST_N), .AVS_ADDRESS(AVS_ADDRESS), .AVS_READ(AVS_READ),
        .AVS_WRITE(AVS_WRITE), .AVS_WRITEDATA(AVS_WRITEDATA), .AVS_BYTEENABLE(4'hf),
        .AVS_READDATA(AVS_READDATA), .AVS_WAITREQUEST(AVS_WAITREQUEST), .RX_VALID(RX_VALID),
        .RX_EXT(RX_EXT), .RX_IDENT(RX_IDENT), .RX_DATA(RX_DATA), .IGN_FEED(IGN_FEED),
        .LOGGER_RUN(LOGGER_RUN), .LOGGER_LOSSLESS(LOGGER_LOSSLESS), .WAKE_LED(WAKE_LED),
        .ALERT(ALERT), .LOG_EVENT(LOG_EVENT), .IRQ(IRQ));
    cwf_node u_node (.CLK(CLK), .RX_VALID(RX_VALID), .RX_EXT(RX_EXT), .RX_IDENT(RX_IDENT),
        .RX_DATA(RX_DATA));
    // Clock
    initial begin
        CLK = 1'b0;
        forever #25 CLK = ~CLK;
    end
    // Compare and count
    task automatic chk(input string nm, input logic [63:0] got, input logic [63:0] exp);
        samples_checked++;
        if (got !== exp) begin
            miscompares++;
            $display("mismatch %s expected %h seen %h", nm, exp, got);
        end
    endtask
    // Avalon cycle held until waitrequest is seen low
    task automatic bus(input logic wr, input logic [5:0] a, input logic [31:0] d);
        @(posedge CLK);
        AVS_ADDRESS <= a;
        AVS_WRITE <= wr;
        AVS_READ <= !wr;
        AVS_WRITEDATA <= d;
        @(negedge CLK);
        while (AVS_WAITREQUEST !== 1'b0) @(negedge CLK);
        @(posedge CLK);
        rd_q = AVS_READDATA; // Taken at the edge that sees waitrequest low
        AVS_WRITE <= 1'b0;
        AVS_READ <= 1'b0;
    endtask
    // Count cycles until the logger is off
    task automatic until_sleep();
        n = 0;
        while (LOGGER_RUN !== 1'b0 && n < 2000) begin
            @(negedge CLK);
            n++;
        end
    endtask
    // Masked data match wakes the logger
    task automatic t_data();
        bus(1, cwf_pkg::REG_DMASK_LO, 32'h00000014);
        bus(1, cwf_pkg::REG_DATA_LO, 32'h00000010);
        bus(1, cwf_pkg::REG_TIMEOUT, 32'h00000028);
        bus(1, cwf_pkg::REG_IRQ_MASK, 32'h00000001);
        bus(1, cwf_pkg::REG_CTRL, 32'h00000001);
        u_node.send(1'b0, 29'h7ff, 64'h1c);
        @(negedge CLK);
        chk("run", LOGGER_RUN, 0);
        u_node.send(1'b0, 29'h7ff, 64'hffffffff_fffffff3);
        @(negedge CLK);
        chk("run", LOGGER_RUN, 1);
        chk("led", WAKE_LED, 0);
        chk("irq", IRQ, 1);
        until_sleep();
        chk("stop_cycles", n >= 41 && n <= 42, 1);
        chk("log", LOG_EVENT, 1);
        chk("alert", ALERT, 1);
        bus(0, cwf_pkg::REG_STATUS, 32'h0);
        chk("status", rd_q[3:0], 4'h3);
        chk("irq", IRQ, 0);
        bus(1, cwf_pkg::REG_CTRL, 32'h00000009);
        @(negedge CLK);
        chk("alert", ALERT, 0);
        $display("t_data done");
    endtask
    // Identifier filter and both-filter wake
    task automatic t_ident();
        bus(1, cwf_pkg::REG_IDENT, 32'h00000016);
        bus(1, cwf_pkg::REG_IDMASK, 32'h0000001c);
        u_node.send(1'b0, 29'h119, 64'h11);
        u_node.send(1'b0, 29'h115, 64'h1c);
        @(negedge CLK);
        chk("run", LOGGER_RUN, 0);
        u_node.send(1'b0, 29'h115, 64'h11);
        @(negedge CLK);
        chk("run", LOGGER_RUN, 1);
        until_sleep();
        bus(1, cwf_pkg::REG_CTRL, 32'h00000009);
        $display("t_ident done");
    endtask
    // Ignition start, frame hold after ignition drop
    task automatic t_ign();
        @(posedge CLK) IGN_FEED <= 1'b1;
        repeat (5) @(posedge CLK);
        @(negedge CLK);
        chk("run", LOGGER_RUN, 1);
        u_node.send(1'b0, 29'h115, 64'h11);
        IGN_FEED <= 1'b0;
        repeat (8) @(negedge CLK);
        chk("run", LOGGER_RUN, 1);
        until_sleep();
        bus(1, cwf_pkg::REG_CTRL, 32'h00000009);
        @(posedge CLK) IGN_FEED <= 1'b1;
        repeat (6) @(posedge CLK);
        IGN_FEED <= 1'b0;
        repeat (6) @(negedge CLK);
        chk("run", LOGGER_RUN, 0);
        $display("t_ign done");
    endtask
    // Every wake mode; disabled mode ignores matches
    task automatic t_modes();
        for (int m = 3; m >= 0; m--) begin
            bus(1, cwf_pkg::REG_CTRL, 32'(m));
            @(negedge CLK);
            chk("lossless", LOGGER_LOSSLESS, m == 2);
        end
        u_node.send(1'b0, 29'h115, 64'h11);
        @(negedge CLK);
        chk("run", LOGGER_RUN, 0);
        $display("t_modes done");
    endtask
    // Verdict and end of run
    task automatic complete_run();
        $display("checks %0d mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    // Main sequence
    initial begin
        {RST_N, AVS_READ, AVS_WRITE, IGN_FEED} = 4'h0;
        AVS_ADDRESS = 6'h00;
        AVS_WRITEDATA = 32'h0;
        repeat (4) @(posedge CLK);
        RST_N <= 1'b1;
        bus(0, cwf_pkg::REG_TIMEOUT, 32'h0);
        chk("timeout_rst", rd_q, cwf_pkg::TIMEOUT_RST);
        bus(0, 6'h3c, 32'h0);
        chk("unmapped", rd_q, cwf_pkg::RD_UNMAPPED);
        t_data();
        t_ident();
        t_ign();
        t_modes();
        complete_run();
    end
    // Watchdog
    initial begin
        repeat (20000) @(posedge CLK);
        miscompares++;
        complete_run();
    end
endmodule // tb
